// ### logic/edge_detect.sv
// Edge detector for one pin, direct or on the slow sampling tick
`timescale 1ns/100ps
module edge_detect
  import port_in_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       sys_rst,
  // Configuration
  input  wire logic [1:0] edge_mode,
  input  wire logic       sampled,
  input  wire logic       tick,
  // Level in, request out
  input  wire logic       level,
  output logic            irq_req
);

  logic       prev_direct;
  logic       sample;
  logic       prev_sample;
  logic       cur;
  logic       prev;
  logic       step;
  logic       next_irq_req;
  logic       tick_d;

  // Direct path compares consecutive synchronised values
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_direct <= 1'b0;
    end else begin
      prev_direct <= level;
    end
  end

  // Sampled path registers the pin only on the tick
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sample      <= 1'b0;
      prev_sample <= 1'b0;
    end else if (tick) begin
      sample      <= level;
      prev_sample <= sample;
    end
  end

  always_comb begin
    cur  = sampled ? sample : level;
    prev = sampled ? prev_sample : prev_direct;
    // New and old samples are both in place the cycle after a tick
    step = sampled ? tick_d : 1'b1;
    next_irq_req = 1'b0;
    case (edge_mode_t'(edge_mode))
      edge_falling: next_irq_req = prev & ~cur;
      edge_rising:  next_irq_req = ~prev & cur;
      edge_both:    next_irq_req = prev ^ cur;
      edge_off:     next_irq_req = 1'b0;
      default:      next_irq_req = 1'b0;
    endcase
    if (sampled && !step) begin
      next_irq_req = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      tick_d <= 1'b0;
    end else begin
      tick_d <= tick;
    end
  end

  // One-cycle request pulse per detected edge
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq_req <= 1'b0;
    end else begin
      irq_req <= next_irq_req;
    end
  end

endmodule : edge_detect

// ### logic/input_port_edge_irq.sv
// Four-bit input port with pull control and edge interrupts
`timescale 1ns/100ps
module input_port_edge_irq
  import port_in_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // Register port
  input  wire logic [15:0]          reg_addr,
  input  wire logic [15:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic                 reg_word,
  output logic      [15:0]          reg_rdata,
  // Pins and pad controls
  input  wire logic [pin_count-1:0] input_pin,
  output logic      [pin_count-1:0] pull_up_en,
  output logic      [pin_count-1:0] pull_down_en,
  // Time base
  input  wire logic                 slow_tick_16k,
  input  wire logic                 stop_mode,
  // Requests and routed levels
  output logic                      pin0_irq_req,
  output logic                      pin1_irq_req,
  output logic                      pin2_irq_req,
  output logic                      pin3_irq_req,
  output logic                      irq,
  output logic      [1:0]           capture_trigger,
  output logic                      uart_rx_input
);

  // ****************************************************
  // Registers
  // ****************************************************
  logic [3:0]           edge_select_low_reg;
  logic [3:0]           edge_select_high_reg;
  logic [3:0]           edge_sampling_reg;
  logic [3:0]           pull_select_low_reg;
  logic [3:0]           pull_select_high_reg;
  logic [3:0]           irq_status;
  logic [3:0]           irq_mask;
  logic [pin_count-1:0] pin_level_bits;
  logic [pin_count-1:0] req;
  logic                 tick_live;
  logic                 status_read;
  logic [15:0]          next_rdata;

  assign status_read = reg_rd && reg_addr == addr_irq_status;

  // ****************************************************
  // Register writes
  // ****************************************************
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      edge_select_low_reg  <= field_reset;
      edge_select_high_reg <= field_reset;
      edge_sampling_reg    <= field_reset;
      irq_mask             <= field_reset;
    end else if (reg_wr) begin
      case (reg_addr)
        addr_edge_select_low:  edge_select_low_reg  <= reg_wdata[3:0];
        addr_edge_select_high: edge_select_high_reg <= reg_wdata[3:0];
        addr_edge_sampling:    edge_sampling_reg    <= reg_wdata[3:0];
        addr_irq_mask:         irq_mask             <= reg_wdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pull_select_low_reg  <= field_reset;
      pull_select_high_reg <= field_reset;
    end else if (reg_wr) begin
      if (reg_addr == addr_pull_select_low) begin
        pull_select_low_reg <= reg_wdata[3:0];
        if (reg_word) begin
          pull_select_high_reg <= reg_wdata[11:8];
        end
      end else if (reg_addr == addr_pull_select_high) begin
        pull_select_high_reg <= reg_wdata[3:0];
      end
    end
  end

  // ****************************************************
  // Read path
  // ****************************************************
  always_comb begin
    next_rdata = word_zero;
    case (reg_addr)
      addr_edge_select_low:  next_rdata[3:0] = edge_select_low_reg;
      addr_edge_select_high: next_rdata[3:0] = edge_select_high_reg;
      addr_edge_sampling:    next_rdata[3:0] = edge_sampling_reg;
      addr_irq_status:       next_rdata[3:0] = irq_status;
      addr_irq_mask:         next_rdata[3:0] = irq_mask;
      addr_pin_level:        next_rdata[3:0] = pin_level_bits;
      addr_pull_select_low: begin
        next_rdata[3:0] = pull_select_low_reg;
        if (reg_word) begin
          next_rdata[11:8] = pull_select_high_reg;
        end
      end
      addr_pull_select_high: next_rdata[3:0] = pull_select_high_reg;
      default:               next_rdata = word_zero;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= word_zero;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= word_zero;
    end
  end

  // ****************************************************
  // Pins and edge detection
  // ****************************************************
  pin_sync u_sync (
    .ref_clk        (ref_clk),
    .sys_rst        (sys_rst),
    .pin_raw        (input_pin),
    .pin_sync_level (pin_level_bits)
  );

  // Tick is ignored while stopped
  assign tick_live = slow_tick_16k & ~stop_mode;

  genvar g;
  generate
    for (g = 0; g < pin_count; g++) begin : g_pin
      edge_detect u_edge (
        .ref_clk   (ref_clk),
        .sys_rst   (sys_rst),
        .edge_mode ({edge_select_high_reg[g], edge_select_low_reg[g]}),
        .sampled   (edge_sampling_reg[g]),
        .tick      (tick_live),
        .level     (pin_level_bits[g]),
        .irq_req   (req[g])
      );

      // Pull decode
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          pull_up_en[g]   <= 1'b0;
          pull_down_en[g] <= 1'b0;
        end else begin
          pull_up_en[g]   <= pull_mode_t'({pull_select_high_reg[g],
                             pull_select_low_reg[g]}) == pull_up;
          pull_down_en[g] <= pull_mode_t'({pull_select_high_reg[g],
                             pull_select_low_reg[g]}) == pull_down;
        end
      end

      // Sticky status; a set wins over the read clear
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          irq_status[g] <= 1'b0;
        end else if (req[g]) begin
          irq_status[g] <= 1'b1;
        end else if (status_read) begin
          irq_status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************
  // Outputs
  // ****************************************************
  assign pin0_irq_req    = req[0];
  assign pin1_irq_req    = req[1];
  assign pin2_irq_req    = req[2];
  assign pin3_irq_req    = req[3];

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      irq             <= 1'b0;
      capture_trigger <= 2'b00;
      uart_rx_input   <= 1'b0;
    end else begin
      irq             <= |(irq_status & irq_mask);
      capture_trigger <= pin_level_bits[1:0];
      uart_rx_input   <= pin_level_bits[2];
    end
  end

endmodule : input_port_edge_irq

// ### logic/pin_sync.sv
// Three-stage synchroniser for the four input pins
`timescale 1ns/100ps
module pin_sync
  import port_in_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // Pins and synchronised level
  input  wire logic [pin_count-1:0] pin_raw,
  output logic      [pin_count-1:0] pin_sync_level
);

  logic [pin_count-1:0] stage1;
  logic [pin_count-1:0] stage2;
  logic [pin_count-1:0] stage3;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      stage1 <= field_reset;
      stage2 <= field_reset;
      stage3 <= field_reset;
    end else begin
      stage1 <= pin_raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts once the second and third stages agree
  genvar g;
  generate
    for (g = 0; g < pin_count; g++) begin : g_agree
      always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
          pin_sync_level[g] <= 1'b0;
        end else if (stage2[g] == stage3[g]) begin
          pin_sync_level[g] <= stage3[g];
        end
      end
    end
  endgenerate

endmodule : pin_sync

// ### logic/port_in_pkg.sv
// Constants and types shared by the input port design
package port_in_pkg;

  // ****************************************************
  // Register map
  // ****************************************************
  localparam logic [15:0] addr_edge_select_low  = 16'hf020;
  localparam logic [15:0] addr_edge_select_high = 16'hf021;
  localparam logic [15:0] addr_edge_sampling    = 16'hf022;
  localparam logic [15:0] addr_irq_status       = 16'hf024;
  localparam logic [15:0] addr_irq_mask         = 16'hf025;
  localparam logic [15:0] addr_pin_level        = 16'hf204;
  localparam logic [15:0] addr_pull_select_low  = 16'hf206;
  localparam logic [15:0] addr_pull_select_high = 16'hf207;

  // ****************************************************
  // Widths and reset values
  // ****************************************************
  localparam int          pin_count   = 4;
  localparam logic [7:0]  reg_reset   = 8'h00;
  localparam logic [3:0]  field_reset = 4'h0;
  localparam logic [15:0] word_zero   = 16'h0000;

  // ****************************************************
  // Encodings
  // ****************************************************
  typedef enum logic [1:0] {
    edge_off     = 2'b00,
    edge_falling = 2'b01,
    edge_rising  = 2'b10,
    edge_both    = 2'b11
  } edge_mode_t;

  typedef enum logic [1:0] {
    pull_none_a = 2'b00,
    pull_down   = 2'b01,
    pull_up     = 2'b10,
    pull_none_b = 2'b11
  } pull_mode_t;

endpackage : port_in_pkg

// ### sim/input_port_edge_irq_asserts.sv
// Checker for the input port's register, pad and request ports
`timescale 1ns/100ps
module input_port_edge_irq_asserts
  import port_in_pkg::*;
(
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  // Register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic       reg_word,
  input wire logic [15:0] reg_rdata,
  // Pins and outputs
  input wire logic [pin_count-1:0] input_pin,
  input wire logic [pin_count-1:0] pull_up_en,
  input wire logic [pin_count-1:0] pull_down_en,
  input wire logic       pin0_irq_req,
  input wire logic       pin3_irq_req,
  input wire logic       irq,
  input wire logic [1:0] capture_trigger,
  input wire logic       uart_rx_input
);
  logic [3:0]  settle;
  logic [15:0] last_wdata;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) settle <= 4'h0;
    else if (settle != 4'hf) settle <= settle + 4'h1;
  end

  always_ff @(posedge ref_clk) begin
    if (reg_wr) last_wdata <= reg_wdata;
  end

  a_rdata_quiet: assert property (!$past(reg_rd) |-> reg_rdata == word_zero)
    else $error("read data outside read slot");
  a_level_upper: assert property ($past(reg_rd) &&
    $past(reg_addr) == addr_pin_level |-> reg_rdata[15:4] == 12'h000)
    else $error("level register upper bits set");
  a_pull_disjoint: assert property ((pull_up_en & pull_down_en) == 4'h0)
    else $error("pull-up and pull-down both on");
  a_pull_reset: assert property ($past(sys_rst) |->
    pull_up_en == 4'h0 && pull_down_en == 4'h0 && !irq)
    else $error("pad not quiet after reset");
  a_reset_quiet: assert property ($past(sys_rst) |->
    !pin0_irq_req && !pin3_irq_req)
    else $error("request right after reset");
  a_word_pull: assert property (reg_wr && reg_word &&
    reg_addr == addr_pull_select_low |-> ##2
    pull_up_en == (last_wdata[11:8] & ~last_wdata[3:0]) &&
    pull_down_en == (last_wdata[3:0] & ~last_wdata[11:8]))
    else $error("word pull write not applied");
  a_low_zero: assert property (reg_wr && !reg_word &&
    reg_addr == addr_pull_select_low && reg_wdata[3:0] == 4'h0
    |-> ##2 pull_down_en == 4'h0)
    else $error("pull-down on with low select clear");
  a_req_pulse0: assert property (pin0_irq_req |=> !pin0_irq_req)
    else $error("pin 0 request longer than a cycle");
  a_req_pulse3: assert property (pin3_irq_req |=> !pin3_irq_req)
    else $error("pin 3 request longer than a cycle");
  a_route_levels: assert property ($stable(input_pin) [*6] ##0
    settle == 4'hf |-> capture_trigger == input_pin[1:0] &&
    uart_rx_input == input_pin[2])
    else $error("routed levels differ from pins");
endmodule : input_port_edge_irq_asserts

bind input_port_edge_irq input_port_edge_irq_asserts chk (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_word(reg_word), .reg_rdata(reg_rdata), .input_pin(input_pin),
  .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
  .pin0_irq_req(pin0_irq_req), .pin3_irq_req(pin3_irq_req), .irq(irq),
  .capture_trigger(capture_trigger), .uart_rx_input(uart_rx_input));

// ### sim/pin_source.sv
// Far-side model of the signal sources on the four input pins
`timescale 1ns/100ps
module pin_source (
  // Clock
  input  wire logic       ref_clk,
  // Source control from the bench
  input  wire logic [3:0] drive_en,
  input  wire logic [3:0] drive_val,
  // Pad pull enables from the port
  input  wire logic [3:0] pull_up_en,
  input  wire logic [3:0] pull_down_en,
  // Pin levels
  output logic      [3:0] pin
);
  logic [3:0] float_q = 4'h5;

  // An undriven, unpulled pin never holds a level
  always @(posedge ref_clk) float_q <= ~float_q;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin[i] = drive_en[i] ? drive_val[i] : pull_up_en[i] ? 1'b1 :
               pull_down_en[i] ? 1'b0 : float_q[i];
    end
  end
endmodule : pin_source

// ### sim/test_input_port_edge_irq.sv
// Self-checking bench for the four-bit input port
`timescale 1ns/100ps
module test_input_port_edge_irq
  import port_in_pkg::*;
;
  logic        ref_clk, sys_rst, reg_wr, reg_rd, reg_word;
  logic        slow_tick_16k, stop_mode, irq, uart_rx_input;
  logic [15:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0]  input_pin, pull_up_en, pull_down_en, drive_en, drive_val, req;
  logic [1:0]  capture_trigger;
  logic [15:0] regs [5];
  logic [7:0]  b;
  int          num_errors, tests_run, cycles, seed, e, cnt [4];
  int          model [int];

  input_port_edge_irq dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_word(reg_word), .reg_rdata(reg_rdata),
    .input_pin(input_pin), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .slow_tick_16k(slow_tick_16k),
    .stop_mode(stop_mode), .pin0_irq_req(req[0]), .pin1_irq_req(req[1]),
    .pin2_irq_req(req[2]), .pin3_irq_req(req[3]), .irq(irq),
    .capture_trigger(capture_trigger), .uart_rx_input(uart_rx_input));

  pin_source src (.ref_clk(ref_clk), .drive_en(drive_en),
    .drive_val(drive_val), .pull_up_en(pull_up_en),
    .pull_down_en(pull_down_en), .pin(input_pin));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) cnt[i] += int'(req[i]);
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      conclude();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [15:0] d,
                    input logic w);
    @(posedge ref_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; reg_word <= w;
    @(posedge ref_clk);
    reg_wr <= 1'b0; reg_word <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : idle

  task automatic tick();
    @(posedge ref_clk) slow_tick_16k <= 1'b1;
    @(posedge ref_clk) slow_tick_16k <= 1'b0;
  endtask : tick

  task automatic conclude();
    if (num_errors == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  initial begin
    seed = 32'h05a6;
    regs = '{addr_edge_select_low, addr_edge_select_high,
             addr_edge_sampling, addr_pull_select_low, addr_pull_select_high};
    {reg_wr, reg_rd, reg_word, slow_tick_16k, stop_mode} = 5'h00;
    reg_addr = 16'h0000; reg_wdata = 16'h0000;
    drive_en = 4'hf; drive_val = 4'h0; sys_rst = 1'b1;
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (regs[i]) rd(regs[i], 16'h0000);
    foreach (regs[i]) begin
      model[regs[i]] = $random(seed) & 8'hff;
      wr(regs[i], 16'(model[regs[i]]), 1'b0);
      rd(regs[i], 16'(model[regs[i]] & 8'h0f));
    end
    wr(addr_edge_select_low, 16'h0000, 1'b0);
    wr(addr_edge_select_high, 16'h0000, 1'b0);
    wr(16'h1234, 16'h00ff, 1'b0);
    rd(16'h1234, 16'h0000);
    drive_val <= 4'($random(seed));
    idle(8);
    rd(addr_pin_level, {12'h000, drive_val});
    check({13'h0000, uart_rx_input, capture_trigger},
          {13'h0000, drive_val[2:0]});
    drive_en <= 4'h0;
    for (int c = 0; c < 4; c++) begin
      wr(addr_pull_select_low, {{4'h0, {4{c[1]}}}, {4'h0, {4{c[0]}}}}, 1'b1);
      idle(8);
      check({pull_up_en, pull_down_en},
            {{4{c[1] & ~c[0]}}, {4{c[0] & ~c[1]}}});
      rd(addr_pull_select_high, {12'h000, {4{c[1]}}});
      if (c == 1 || c == 2) rd(addr_pin_level, {12'h000, {4{c[1]}}});
    end
    wr(addr_pull_select_low, 16'h0000, 1'b0);
    idle(2);
    check({8'h00, pull_up_en, pull_down_en}, 16'h00f0);
    drive_en <= 4'hf; drive_val <= 4'h0;
    wr(addr_irq_mask, 16'h000f, 1'b0);
    wr(addr_edge_sampling, 16'h0000, 1'b0);
    for (int p = 0; p < 4; p++) begin
      for (int m = 0; m < 4; m++) begin
        b = 8'h00; b[p] = m[0];
        wr(addr_edge_select_low, {8'h00, b}, 1'b0);
        b[p] = m[1];
        wr(addr_edge_select_high, {8'h00, b}, 1'b0);
        idle(8);
        rd(addr_irq_status, 16'h0000);
        cnt = '{0, 0, 0, 0};
        drive_val[p] <= 1'b1;
        idle(10);
        drive_val[p] <= 1'b0;
        idle(10);
        e = (m == 3) ? 2 : (m != 0);
        check(16'(cnt[0] + cnt[1] + cnt[2] + cnt[3]), 16'(e));
        check(16'(cnt[p]), 16'(e));
        check({15'h0000, irq}, {15'h0000, e != 0});
        rd(addr_irq_status, (e != 0) ? 16'h0001 << p : 16'h0000);
        idle(2);
        check({15'h0000, irq}, 16'h0000);
      end
    end
    wr(addr_edge_select_low, 16'h0000, 1'b0);
    wr(addr_edge_select_high, 16'h0002, 1'b0);
    wr(addr_edge_sampling, 16'h0002, 1'b0);
    tick();
    idle(4);
    cnt = '{0, 0, 0, 0};
    drive_val[1] <= 1'b1;
    idle(10);
    check(16'(cnt[1]), 16'h0000);
    tick();
    idle(6);
    check(16'(cnt[1]), 16'h0001);
    stop_mode <= 1'b1;
    drive_val[1] <= 1'b0;
    idle(8);
    tick();
    idle(4);
    drive_val[1] <= 1'b1;
    idle(8);
    tick();
    idle(6);
    stop_mode <= 1'b0;
    idle(6);
    check(16'(cnt[1]), 16'h0001);
    conclude();
  end
endmodule : test_input_port_edge_irq
